/* File: hdl/cti_pkg.sv */
// constants, register map and field layout of the calendar timer
package cti_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUSY_T_NS = 15;
  localparam int CLKB_T_NS = 40;
  localparam int BUSY_CYC = (BUSY_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLKB_CYC = (CLKB_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_CALENDAR_VALUE = 8'h04;
  localparam logic [AW-1:0] A_ALM0 = 8'h08;
  localparam logic [AW-1:0] A_ALM_STEP = 8'h04;
  localparam logic [AW-1:0] A_PSEL = 8'h10;
  localparam logic [AW-1:0] A_STAT = 8'h18;
  localparam logic [AW-1:0] A_SCR = 8'h1C;
  localparam logic [AW-1:0] A_IER = 8'h20;
  localparam logic [AW-1:0] A_IDR = 8'h24;
  localparam logic [AW-1:0] A_IMR = 8'h28;
  localparam logic [AW-1:0] A_CLK = 8'h2C;
  localparam logic [AW-1:0] A_DTR = 8'h44;
  localparam int CT_EN = 0;
  localparam int CT_CAL = 1;
  localparam int CT_CA = 2;
  localparam int CT_PSEL_LO = 8;
  localparam int PSEL_W = 5;
  localparam int PS_STEP = 8;
  localparam int CK_EN = 0;
  localparam logic [DW-1:0] CTRL_MASK = 32'h00001F07;
  localparam logic [DW-1:0] PSEL_MASK = 32'h00001F1F;
  localparam logic [DW-1:0] CLK_MASK = 32'h00000001;
  localparam logic [DW-1:0] DTR_MASK = 32'h0000FF3F;
  localparam int NIRQ = 7;
  localparam int IB_OVF = 0;
  localparam int IB_PERIODIC_IRQ_0 = 1;
  localparam int IB_PERIODIC_IRQ_1 = 2;
  localparam int IB_ALM0 = 3;
  localparam int IB_ALM1 = 4;
  localparam int IB_CLKRDY = 5;
  localparam int IB_RDY = 6;
  localparam int SB_BUSY = 8;
  localparam int SB_CLKB = 9;
  localparam int DT_EXP_LO = 0;
  localparam int EXP_W = 5;
  localparam int DT_ADD = 5;
  localparam int DT_VAL_LO = 8;
  localparam int VAL_W = 8;
  localparam int PER_W = 40;
  localparam int TUNE_NUM = 256;
  localparam int SEC_LO = 0;
  localparam int MIN_LO = 6;
  localparam int HOUR_LO = 12;
  localparam int DAY_LO = 17;
  localparam int MON_LO = 22;
  localparam int YEAR_LO = 26;
  localparam int LEAP_W = 2;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] YEAR_MAX = 6'h3F;
  localparam logic [4:0] DAY_FIRST = 5'h01;
  localparam logic [3:0] MON_FIRST = 4'h1;
  localparam logic [3:0] MON_MAX = 4'hC;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [3:0] MON_APR = 4'h4;
  localparam logic [3:0] MON_JUN = 4'h6;
  localparam logic [3:0] MON_SEP = 4'h9;
  localparam logic [3:0] MON_NOV = 4'hB;
  localparam logic [4:0] DAYS_28 = 5'h1C;
  localparam logic [4:0] DAYS_29 = 5'h1D;
  localparam logic [4:0] DAYS_30 = 5'h1E;
  localparam logic [4:0] DAYS_31 = 5'h1F;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

/* File: hdl/cti_if.sv */
// link between the control slice and the calendar counter
`timescale 1ns/1ps
`default_nettype none
interface cti_if;
  logic        tick;
  logic        cal_mode;
  logic        clr;
  logic        load;
  logic [31:0] ldata;
  logic [31:0] value;
  logic        wrap;
  modport ctl (output tick, cal_mode, clr, load, ldata, input value, wrap);
  modport cnt (input tick, cal_mode, clr, load, ldata, output value, wrap);
endinterface
`default_nettype wire

/* File: hdl/cti_cal.sv */
// counter and calendar value register
`timescale 1ns/1ps
`default_nettype none
module cti_cal (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // counter control and value
  cti_if.cnt       cb
);
  import cti_pkg::*;

  logic [31:0] v_r;
  logic [31:0] v_nxt;
  logic        wrap_r;
  logic        wrap_nxt;
  logic [5:0]  sec;
  logic [5:0]  mn;
  logic [4:0]  hr;
  logic [4:0]  dy;
  logic [3:0]  mo;
  logic [5:0]  yr;
  logic        day_end;

  assign sec = v_r[SEC_LO +: 6];
  assign mn = v_r[MIN_LO +: 6];
  assign hr = v_r[HOUR_LO +: 5];
  assign dy = v_r[DAY_LO +: 5];
  assign mo = v_r[MON_LO +: 4];
  assign yr = v_r[YEAR_LO +: 6];
  assign cb.value = v_r;
  assign cb.wrap = wrap_r;

  // leap when the year offset is a multiple of four
  function automatic logic [4:0] dim(input logic [3:0] m, input logic [5:0] y);
    if (m == MON_FEB)
      dim = (y[LEAP_W-1:0] == 2'h0) ? DAYS_29 : DAYS_28; // RL6
    else if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV)
      dim = DAYS_30;
    else
      dim = DAYS_31;
  endfunction

  always_comb
  begin
    v_nxt = v_r;
    wrap_nxt = 1'b0;
    if (cb.load)
      v_nxt = cb.ldata;
    else if (cb.clr)
      v_nxt = 32'h0;
    else if (cb.tick && !cb.cal_mode)
      {wrap_nxt, v_nxt} = 33'(v_r) + 33'h1;
    else if (cb.tick)
    begin
      // RL1
      v_nxt[SEC_LO +: 6] = (sec == SEC_MAX) ? 6'h0 : sec + 6'h1; // RL3
      if (sec == SEC_MAX)
      begin
        v_nxt[MIN_LO +: 6] = (mn == MIN_MAX) ? 6'h0 : mn + 6'h1;
        if (mn == MIN_MAX)
        begin
          v_nxt[HOUR_LO +: 5] = (hr == HOUR_MAX) ? 5'h0 : hr + 5'h1; // RL3
          if (hr == HOUR_MAX)
          begin
            v_nxt[DAY_LO +: 5] = (dy == dim(mo, yr)) ? DAY_FIRST : dy + 5'h1; // RL19
            if (dy == dim(mo, yr))
            begin
              v_nxt[MON_LO +: 4] = (mo == MON_MAX) ? MON_FIRST : mo + 4'h1; // RL4
              if (mo == MON_MAX)
              begin
                v_nxt[YEAR_LO +: 6] = yr + 6'h1; // RL5
                wrap_nxt = (yr == YEAR_MAX);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      v_r <= 32'h0;
      wrap_r <= 1'b0;
    end
    else
    begin
      v_r <= v_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  assign day_end = cb.tick && cb.cal_mode && !cb.load && !cb.clr
                   && sec == SEC_MAX && mn == MIN_MAX && hr == HOUR_MAX;

  default clocking cb_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_sec_wrap;
    cb.tick && cb.cal_mode && !cb.load && !cb.clr && sec == SEC_MAX
      |=> sec == 6'h0 && mn != $past(mn);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap"); // RL3

  property p_day_roll;
    day_end && dy == dim(mo, yr) |=> dy == DAY_FIRST && mo != $past(mo);
  endproperty
  a_day_roll: assert property (p_day_roll) else $error("day did not roll over"); // RL19

  property p_leap;
    day_end && mo == MON_FEB && dy == DAYS_28 && yr[LEAP_W-1:0] == 2'h0
      |=> dy == DAYS_29 && mo == MON_FEB;
  endproperty
  a_leap: assert property (p_leap) else $error("leap day skipped"); // RL6
endmodule
`default_nettype wire

/* File: hdl/cti_top.sv */
// calendar timer with interrupts, periodic events and frequency tuner
// Notes on behaviour
// RL1: calendar bit set makes the counter a calendar, read and written as one word.
// RL2: software sets the prescaler to a one-second pulse before calendar mode.
// RL3: time kept as seconds, minutes and hours, hours in 24-hour form.
// RL4: day of month starts at one; month one is January.
// RL5: year is a 6-bit offset from a software-chosen leap year.
// RL6: every year offset divisible by four is treated as leap.
// RL7: events alike in both modes; alarms in calendar layout in calendar mode.
// RL8: five request sources: overflow, periodic, alarm, clock ready, interface ready.
// RL9: overflow event on wrap, and on alarm 0 match when clear-on-alarm is set.
// RL10: clock-ready event when the clock-sync busy flag falls.
// RL11: interface-ready event when the interface busy flag falls.
// RL12: request only while its mask bit is set; enable sets, disable clears.
// RL13: request stays until software writes one to the status clear bit.
// RL14: requests are plain levels, usable as wake sources while clocks run.
// RL15: periodic event on each rising edge of the selected prescaler bit.
// RL16: while busy, tuner writes are dropped and tuner reads give zero.
// RL17: tuner magnitude zero leaves the rate alone; nonzero enables tuning.
// RL18: tuner drops or adds one step every ceil(256/value)*2^exp steps.
// RL19: in calendar mode the day wraps to one and advances the month.
`timescale 1ns/1ps
`default_nettype none
module cti_top #(
  parameter int PSC_W = 32
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write channels
  input  wire logic [cti_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [cti_pkg::DW-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read channels
  input  wire logic [cti_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [cti_pkg::DW-1:0] s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // interrupt requests
  output var  logic                   irq,
  output var  logic                   irq_ovf,
  output var  logic                   irq_per,
  output var  logic                   irq_alarm,
  output var  logic                   irq_clk_ready,
  output var  logic                   irq_ready
);
  import cti_pkg::*;

  generate
    if (PSC_W < (1 << PSEL_W) || PSC_W > 64)
    begin : g_chk
      $error("PSC_W must lie between 32 and 64");
    end
  endgenerate

  // bus slave state
  logic            awready_r;
  logic            wready_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            arready_r;
  logic            rvalid_r;
  logic [DW-1:0]   rdata_r;
  logic [1:0]      rresp_r;
  logic            aw_full_r;
  logic            w_full_r;
  logic [AW-1:0]   waddr_r;
  logic [DW-1:0]   wdata_r;
  logic [3:0]      wstrb_r;
  // block registers
  logic [DW-1:0]   ctrl_r;
  logic [DW-1:0]   psel_r;
  logic [DW-1:0]   clk_r;
  logic [DW-1:0]   dtr_r;
  logic [DW-1:0]   alm_r [2];
  logic [NIRQ-1:0] st_r;
  logic [NIRQ-1:0] imr_r;
  logic [CNT_W-1:0] busy_cnt_r;
  logic [CNT_W-1:0] clkb_cnt_r;
  logic            busy_d_r;
  logic            clkb_d_r;
  logic            tick_d_r;
  logic [PSC_W-1:0] psc_r;
  logic [PER_W-1:0] tc_r;
  logic            irq_r;
  logic [4:0]      irqs_r;

  cti_if cif ();

  cti_cal u_cal (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cb      (cif)
  );

  // write path: address and data may arrive in either order
  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take = s_axi_wvalid & wready_r;
  wire wr_do = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_full_nxt = (aw_full_r | aw_take) & ~wr_do;
  wire w_full_nxt = (w_full_r | w_take) & ~wr_do;
  wire bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready);
  wire ar_take = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

  logic [DW-1:0] wm;
  genvar gb;
  for (gb = 0; gb < 4; gb++)
  begin : g_strb
    assign wm[8*gb +: 8] = {8{wstrb_r[gb]}};
  end
  wire [DW-1:0] wbits = wdata_r & wm;

  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o);
    mrg = (o & ~wm) | wbits;
  endfunction

  wire busy = (busy_cnt_r != '0);
  wire clock_sync_pending = (clkb_cnt_r != '0);
  wire wr_ctrl = wr_do & (waddr_r == A_CTRL);
  wire wr_calendar_value = wr_do & (waddr_r == A_CALENDAR_VALUE);
  wire wr_psel = wr_do & (waddr_r == A_PSEL);
  wire wr_scr = wr_do & (waddr_r == A_SCR);
  wire wr_ier = wr_do & (waddr_r == A_IER);
  wire wr_idr = wr_do & (waddr_r == A_IDR);
  wire wr_clk = wr_do & (waddr_r == A_CLK);
  wire wr_dtr = wr_do & (waddr_r == A_DTR);
  wire wr_dtr_ok = wr_dtr & ~busy; // RL16
  logic [1:0] wr_alm;
  wire wr_ro = wr_do & (waddr_r == A_STAT || waddr_r == A_IMR);
  wire w_map = wr_ctrl | wr_calendar_value | wr_psel | wr_scr | wr_ier | wr_idr
               | wr_clk | wr_dtr | (|wr_alm) | wr_ro;
  wire wr_sync = wr_ctrl | wr_calendar_value | wr_psel | wr_dtr | (|wr_alm);
  wire [NIRQ-1:0] scr_m = wr_scr ? wbits[NIRQ-1:0] : '0;
  wire [NIRQ-1:0] ier_m = wr_ier ? wbits[NIRQ-1:0] : '0;
  wire [NIRQ-1:0] idr_m = wr_idr ? wbits[NIRQ-1:0] : '0;

  // prescaler with digital tuner
  wire run = ctrl_r[CT_EN] & clk_r[CK_EN];
  wire [VAL_W-1:0] val = dtr_r[DT_VAL_LO +: VAL_W];
  wire [EXP_W-1:0] tn_exp = dtr_r[DT_EXP_LO +: EXP_W];
  wire add = dtr_r[DT_ADD];
  wire [VAL_W-1:0] val_nz = (val == '0) ? VAL_W'(1) : val;
  wire [8:0] tn_base = 9'((TUNE_NUM + 32'(val_nz) - 1) / 32'(val_nz));
  wire [PER_W-1:0] tn_per = PER_W'(tn_base) << tn_exp;
  wire [PER_W-1:0] tc_end = add ? tn_per - PER_W'(2) : tn_per;
  wire at_end = (tc_r == tc_end);
  // RL17 RL18
  wire [1:0] step = !run ? 2'h0 : (val == '0) ? 2'h1 : !at_end ? 2'h1 : add ? 2'h2 : 2'h0;
  wire [PER_W-1:0] tc_nxt = (!run || val == '0 || at_end) ? '0 : tc_r + PER_W'(1);
  wire [PSC_W-1:0] psc_nxt = psc_r + PSC_W'(step);
  wire [PSEL_W-1:0] tsel = ctrl_r[CT_PSEL_LO +: PSEL_W];
  // rising edge only, so a skipped step can never double a tick
  wire tick = ~psc_r[tsel] & psc_nxt[tsel];

  logic [1:0] per_ev;
  logic [1:0] alm_hit;
  genvar gk;
  for (gk = 0; gk < 2; gk++)
  begin : g_ch
    wire [PSEL_W-1:0] ps = psel_r[PS_STEP*gk +: PSEL_W];
    assign per_ev[gk] = ~psc_r[ps] & psc_nxt[ps]; // RL15
    assign wr_alm[gk] = wr_do & (waddr_r == AW'(A_ALM0 + AW'(gk) * A_ALM_STEP));
    // compare after the value has moved; same word in both modes
    assign alm_hit[gk] = tick_d_r & (cif.value == alm_r[gk]); // RL7
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        alm_r[gk] <= 32'h0;
      else if (wr_alm[gk])
        alm_r[gk] <= mrg(alm_r[gk]);
    end
  end

  assign cif.tick = tick;
  assign cif.cal_mode = ctrl_r[CT_CAL]; // RL1
  assign cif.clr = ctrl_r[CT_CA] & alm_hit[0] & ~wr_calendar_value;
  assign cif.load = wr_calendar_value;
  assign cif.ldata = mrg(cif.value);

  // events into sticky status; a set beats a clear in the same cycle
  logic [NIRQ-1:0] ev;
  assign ev[IB_OVF] = cif.wrap | cif.clr; // RL9
  assign ev[IB_PERIODIC_IRQ_0] = per_ev[0];
  assign ev[IB_PERIODIC_IRQ_1] = per_ev[1];
  assign ev[IB_ALM0] = alm_hit[0];
  assign ev[IB_ALM1] = alm_hit[1];
  assign ev[IB_CLKRDY] = clkb_d_r & ~clock_sync_pending; // RL10
  assign ev[IB_RDY] = busy_d_r & ~busy; // RL11
  wire [NIRQ-1:0] st_nxt = (st_r & ~scr_m) | ev; // RL13
  wire [NIRQ-1:0] imr_nxt = (imr_r | ier_m) & ~idr_m; // RL12
  wire [NIRQ-1:0] pend = st_r & imr_r; // RL12
  wire [4:0] irqs_nxt = {pend[IB_RDY], pend[IB_CLKRDY], pend[IB_ALM0] | pend[IB_ALM1],
                         pend[IB_PERIODIC_IRQ_0] | pend[IB_PERIODIC_IRQ_1], pend[IB_OVF]}; // RL8

  wire [CNT_W-1:0] busy_nxt = wr_sync ? CNT_W'(BUSY_CYC) : busy ? busy_cnt_r - 1'b1 : '0;
  wire [CNT_W-1:0] clkb_nxt = wr_clk ? CNT_W'(CLKB_CYC) : clock_sync_pending ? clkb_cnt_r - 1'b1 : '0;

  // read decode
  wire [AW-1:0] ra = s_axi_araddr;
  wire [DW-1:0] stat_w = DW'(st_r) | (DW'(busy) << SB_BUSY) | (DW'(clock_sync_pending) << SB_CLKB);
  wire [DW-1:0] rd_val = (ra == A_CTRL) ? ctrl_r :
                         (ra == A_CALENDAR_VALUE) ? cif.value :
                         (ra == A_ALM0) ? alm_r[0] :
                         (ra == A_ALM0 + A_ALM_STEP) ? alm_r[1] :
                         (ra == A_PSEL) ? psel_r :
                         (ra == A_STAT) ? stat_w :
                         (ra == A_IMR) ? DW'(imr_r) :
                         (ra == A_CLK) ? clk_r :
                         (ra == A_DTR && !busy) ? dtr_r : 32'h0; // RL16
  wire rd_map = ra == A_CTRL || ra == A_CALENDAR_VALUE || ra == A_ALM0 || ra == A_ALM0 + A_ALM_STEP
                || ra == A_PSEL || ra == A_STAT || ra == A_SCR || ra == A_IER
                || ra == A_IDR || ra == A_IMR || ra == A_CLK || ra == A_DTR;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OK;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OK;
      waddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else
    begin
      awready_r <= ~aw_full_nxt;
      wready_r <= ~w_full_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      bvalid_r <= bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (aw_take)
        waddr_r <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do)
        bresp_r <= w_map ? RESP_OK : RESP_ERR;
      if (ar_take)
      begin
        rdata_r <= rd_val;
        rresp_r <= rd_map ? RESP_OK : RESP_ERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= 32'h0;
      psel_r <= 32'h0;
      clk_r <= 32'h0;
      dtr_r <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= mrg(ctrl_r) & CTRL_MASK;
      if (wr_psel)
        psel_r <= mrg(psel_r) & PSEL_MASK;
      if (wr_clk)
        clk_r <= mrg(clk_r) & CLK_MASK;
      if (wr_dtr_ok)
        dtr_r <= mrg(dtr_r) & DTR_MASK; // RL16
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      imr_r <= '0;
      busy_cnt_r <= '0;
      clkb_cnt_r <= '0;
      busy_d_r <= 1'b0;
      clkb_d_r <= 1'b0;
      tick_d_r <= 1'b0;
      psc_r <= '0;
      tc_r <= '0;
      irq_r <= 1'b0;
      irqs_r <= 5'h00;
    end
    else
    begin
      st_r <= st_nxt;
      imr_r <= imr_nxt;
      busy_cnt_r <= busy_nxt;
      clkb_cnt_r <= clkb_nxt;
      busy_d_r <= busy;
      clkb_d_r <= clock_sync_pending;
      tick_d_r <= tick;
      psc_r <= psc_nxt;
      tc_r <= tc_nxt;
      irq_r <= |pend; // RL14
      irqs_r <= irqs_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;
  assign irq_ovf = irqs_r[0];
  assign irq_per = irqs_r[1];
  assign irq_alarm = irqs_r[2];
  assign irq_clk_ready = irqs_r[3];
  assign irq_ready = irqs_r[4];

  default clocking cb_top @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_tun_wr;
    wr_dtr && busy |=> dtr_r == $past(dtr_r);
  endproperty
  a_tun_wr: assert property (p_tun_wr) else $error("tuner written while busy"); // RL16

  property p_tun_rd;
    ar_take && ra == A_DTR && busy |=> rdata_r == 32'h0;
  endproperty
  a_tun_rd: assert property (p_tun_rd) else $error("tuner read nonzero while busy"); // RL16

  property p_irq_gate;
    (imr_r == '0) [*2] |-> !irq_r && irqs_r == 5'h00;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without mask"); // RL12

  property p_sticky;
    1'b1 |=> (($past(st_r) & ~$past(scr_m) & ~st_r) == '0) && (($past(ev) & ~st_r) == '0);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost or event dropped"); // RL13

  property p_rdy;
    $fell(busy) |=> st_r[IB_RDY];
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not flagged"); // RL11

  property p_clkrdy;
    $fell(clock_sync_pending) |=> st_r[IB_CLKRDY];
  endproperty
  a_clkrdy: assert property (p_clkrdy) else $error("clock ready not flagged"); // RL10

  property p_ca;
    alm_hit[0] && ctrl_r[CT_CA] && !wr_calendar_value |=> st_r[IB_OVF] && cif.value == 32'h0;
  endproperty
  a_ca: assert property (p_ca) else $error("clear on alarm failed"); // RL9

  property p_tun_rate;
    run && val != '0 && !add && at_end
      |=> $stable(psc_r) ##1 psc_r == $past(psc_r) + PSC_W'($past(run));
  endproperty
  a_tun_rate: assert property (p_tun_rate) else $error("tuner step not dropped"); // RL18

  property p_tun_off;
    run && val == '0 |=> psc_r == $past(psc_r) + 1'b1;
  endproperty
  a_tun_off: assert property (p_tun_off) else $error("untuned rate altered"); // RL17
endmodule
`default_nettype wire

/* File: verification/cti_host.sv */
// axi4-lite master standing in for the cpu side of the timer
`timescale 1ns/1ps
`default_nettype none
module cti_host (
  // clock
  input  wire logic        aclk,
  // write channels
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  // read channels
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // each channel holds until its own ready; response awaited without a cycle count
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/calendar_timer_irq_tuner_tb.sv */
// self-checking bench for the calendar timer, its interrupts and tuner
`timescale 1ns/1ps
`default_nettype none
module calendar_timer_irq_tuner_tb;
  import cti_pkg::*;
  logic          aclk, aresetn;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DW-1:0] s_axi_wdata, s_axi_rdata, v, e, c0;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic          s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic          irq, irq_ovf, irq_per, irq_alarm, irq_clk_ready, irq_ready;
  wire  [5:0]    irq_v = {irq_ready, irq_clk_ready, irq_alarm, irq_per, irq_ovf, irq};
  int            n_errors = 0;
  int            samples_checked = 0;
  int            seed, mask_mdl;
  // year, month and day of each start date; the time is always 23:59:59
  logic [14:0]   cal_tab[5] = '{15'h085C, 15'h085D, 15'h0A5C, 15'h7F9F, 15'h029E};

  cti_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .irq_ovf, .irq_per, .irq_alarm, .irq_clk_ready, .irq_ready);
  cti_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  function automatic logic [31:0] cal_next(input logic [31:0] c);
    int s, mi, h, d, mo, y, dim;
    s = c[5:0] + 1;
    mi = c[11:6] + s / 60;
    h = c[16:12] + mi / 60;
    d = c[21:17] + h / 24;
    mo = c[25:22];
    y = c[31:26];
    dim = (mo == 2) ? 28 + (y % 4 == 0) : (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
    if (d > dim)
    begin
      d = 1;
      mo++;
    end
    if (mo > 12)
    begin
      mo = 1;
      y++;
    end
    return {6'(y % 64), 4'(mo), 5'(d), 5'(h % 24), 6'(mi % 60), 6'(s % 60)};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] want, input string nm);
    u_host.rd(a, v, rs);
    chk(nm, v, want);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_host.wr(a, d, rs);
  endtask
  // irq outputs lag the status by a cycle, so look after two edges
  task automatic settle(input logic want, input int b, input string nm);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(nm, {31'h0, irq_v[b]}, {31'h0, want});
  endtask
  task automatic wait_bit(input int b);
    v = '0;
    for (int i = 0; i < 200 && v[b] !== 1'b1; i++)
      u_host.rd(A_STAT, v, rs);
    chk("status bit", {31'h0, v[b]}, 32'h1);
  endtask
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial
  begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    summarize();
  end

  initial
  begin
    seed = 61;
    mask_mdl = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(A_DTR, 32'h0, "dtr reset");
    rchk(A_IMR, 32'h0, "mask reset");
    rchk(A_STAT, 32'h0, "status reset");
    u_host.rd(8'h40, v, rs);
    chk("unmapped rresp", {30'h0, rs}, {30'h0, RESP_ERR});
    u_host.wr(8'h40, 32'h1, rs);
    chk("unmapped bresp", {30'h0, rs}, {30'h0, RESP_ERR});
    w(A_CLK, 32'h1);
    wait_bit(IB_CLKRDY);
    w(A_IER, 32'h20);
    settle(1'b1, 4, "clock ready irq");
    w(A_IDR, 32'h20);
    settle(1'b0, 4, "clock ready disabled");
    w(A_DTR, 32'hFFFF80C0);
    rchk(A_DTR, 32'h0, "tuner while busy");
    wait_bit(IB_RDY);
    rchk(A_DTR, 32'hFFFF80C0 & DTR_MASK, "tuner");
    settle(1'b0, 5, "ready unmasked");
    w(A_IER, 32'h40);
    mask_mdl |= 32'h40;
    rchk(A_IMR, mask_mdl, "mask set");
    settle(1'b1, 5, "ready irq");
    w(A_IDR, 32'h40);
    mask_mdl &= ~32'h40;
    settle(1'b0, 0, "ready disabled");
    w(A_IER, 32'h40);
    w(A_SCR, 32'h40);
    settle(1'b0, 5, "ready cleared");
    w(A_IER, 32'h06);
    w(A_PSEL, 32'h00000403);
    w(A_CTRL, 32'h1);
    wait_bit(IB_PERIODIC_IRQ_0);
    wait_bit(IB_PERIODIC_IRQ_1);
    settle(1'b1, 2, "periodic irq");
    w(A_CTRL, 32'h0);
    w(A_CALENDAR_VALUE, 32'hFFFFFFFF);
    w(A_IER, 32'h01);
    w(A_CTRL, 32'h1);
    wait_bit(IB_OVF);
    settle(1'b1, 1, "overflow irq");
    w(A_CTRL, 32'h0);
    // the wrap to zero matched both zero alarms; clear those too
    w(A_SCR, 32'h19);
    settle(1'b0, 1, "overflow cleared");
    c0 = {cal_tab[0], 5'h17, 6'h3B, 6'h3B};
    w(A_ALM0, cal_next(c0));
    w(A_DTR, 32'h0);
    foreach (cal_tab[i])
    begin
      c0 = {cal_tab[i], 5'h17, 6'h3B, 6'h3B};
      w(A_CTRL, 32'h0);
      w(A_CALENDAR_VALUE, c0);
      // tick select is set in the same write that turns calendar mode on
      w(A_CTRL, 32'h00000403);
      v = c0;
      for (int k = 0; k < 100 && v === c0; k++)
        u_host.rd(A_CALENDAR_VALUE, v, rs);
      chk("calendar step", v, cal_next(c0));
    end
    wait_bit(IB_ALM0);
    w(A_IER, 32'h08);
    settle(1'b1, 3, "alarm irq");
    w(A_CTRL, 32'h0);
    w(A_CALENDAR_VALUE, 32'h0);
    w(A_ALM0, 32'h3);
    w(A_SCR, 32'h01);
    w(A_CTRL, 32'h5);
    // counting up from zero, only clear-on-alarm can raise overflow
    wait_bit(IB_OVF);
    repeat (4)
    begin
      e = $random(seed);
      w(A_ALM0 + A_ALM_STEP, e);
      rchk(A_ALM0 + A_ALM_STEP, e, "alarm compare");
    end
    summarize();
  end
endmodule
`default_nettype wire
